/* File: scs_pkg.sv */
package scs_pkg;

  // ********************************************************
  // Module addresses
  // ********************************************************
  localparam int ADDR_DECODE_W = 8;
  localparam int NUM_SRC = 3;
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_RESULT [0:2] = '{8'h01, 8'h04, 8'h07};
  localparam logic [7:0] ADDR_SETUP_A [0:2] = '{8'h02, 8'h05, 8'h08};
  localparam logic [7:0] ADDR_SETUP_B [0:2] = '{8'h03, 8'h06, 8'h09};

  // ********************************************************
  // Action port bits
  // ********************************************************
  localparam int ACTION_GO_BIT = 15;
  localparam int ACTION_READ_BIT = 14;

  // ********************************************************
  // Control register fields
  // ********************************************************
  localparam int SEL_LSB = 8;
  localparam int START_CH1_BIT = 2;
  localparam int START_CH2_BIT = 1;
  localparam int START_TEMP_BIT = 0;
  localparam logic [15:0] START_BITS_MASK = 16'h0007;

  // ********************************************************
  // Setup register fields
  // ********************************************************
  localparam int GAIN_LSB = 11;
  localparam int CLK_LSB = 8;
  localparam int RES_LSB = 4;
  localparam int OFFSET_SIGN_BIT = 3;
  localparam int OFFSET_MAG_LSB = 0;
  localparam int BIAS_LSB = 4;
  localparam int REF_LSB = 0;

  // ********************************************************
  // Implemented bits and reset values
  // ********************************************************
  localparam logic [15:0] MASK_CONTROL = 16'h0f07;
  localparam logic [15:0] MASK_SETUP_A [0:2] = '{16'hff7f, 16'hff7f, 16'h077f};
  localparam logic [15:0] MASK_SETUP_B [0:2] = '{16'h0073, 16'h0073, 16'h0070};
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [15:0] RST_RESULT = 16'h0000;
  localparam logic [15:0] RST_SETUP_A = 16'h0000;
  localparam logic [15:0] RST_SETUP_B = 16'h0070;

  // ********************************************************
  // Source selector codes
  // ********************************************************
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_BANDGAP = 4'h1;
  localparam logic [3:0] SEL_SMALL_AMP = 4'h2;
  localparam logic [3:0] SEL_LARGE_AMP = 4'h3;
  localparam logic [3:0] SEL_SUPPLY = 4'h4;
  localparam logic [3:0] SEL_GROUND = 4'h5;
  localparam logic [3:0] SEL_BUF_SMALL = 4'h6;
  localparam logic [3:0] SEL_BUF_LARGE = 4'h7;
  localparam logic [3:0] SEL_POS_IN = 4'h8;
  localparam logic [3:0] SEL_NEG_IN = 4'h9;

  // ********************************************************
  // Converter timing
  // ********************************************************
  localparam int MCLK_HZ = 100_000_000;
  localparam int FCLK_HZ = 4_000_000;
  localparam int FCLK_DIV_CYCLES = MCLK_HZ / FCLK_HZ;
  localparam int PRE_W = 5;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(FCLK_DIV_CYCLES - 1);
  localparam int DIV_W = 9;
  localparam int ADC_BASE_DIVISOR = 4;
  localparam int CONV_CNT_W = 12;
  localparam logic [11:0] CONV_CLOCKS [0:7] = '{12'h100, 12'h140, 12'h200, 12'h280,
                                                12'h320, 12'h500, 12'h800, 12'h800};

  typedef enum logic [1:0] {
    SRC_CH1 = 2'h0,
    SRC_CH2 = 2'h1,
    SRC_TEMP = 2'h2
  } scs_src_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONVERT = 2'b10
  } scs_state_t;

endpackage : scs_pkg

/* File: scs_conv_if.sv */
`timescale 1ns/100ps
interface scs_conv_if;
  logic start;
  logic [2:0] clk_sel;
  logic [2:0] res_sel;
  logic adc_tick;
  logic done;
  modport seq (output start, output clk_sel, output res_sel, input adc_tick, input done);
  modport div (input start, input clk_sel, output adc_tick);
  modport tmr (input start, input res_sel, input adc_tick, output done);
endinterface : scs_conv_if

/* File: scs_adc_clk_div.sv */
`timescale 1ns/100ps
module scs_adc_clk_div (
  // Clock and reset
  input logic mclk,
  input logic reset_n,
  // Conversion link
  scs_conv_if.div cv
);
  import scs_pkg::*;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [DIV_W-1:0] div;
    logic tick;
  } scs_div_t;

  scs_div_t s;
  scs_div_t next_s;

  // Last count of the converter clock divisor
  function automatic logic [DIV_W-1:0] div_last(input logic [2:0] sel);
    logic [DIV_W:0] full;
    full = (DIV_W+1)'(ADC_BASE_DIVISOR) << sel;
    div_last = DIV_W'(full - 1'b1);
  endfunction : div_last

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (cv.start) begin
      // Realign phase at each conversion
      next_s.pre = '0;
      next_s.div = '0;
    end else if (s.pre == PRE_LAST) begin
      next_s.pre = '0;
      if (s.div == div_last(cv.clk_sel)) begin
        next_s.div = '0;
        next_s.tick = 1'b1;
      end else begin
        next_s.div = s.div + 1'b1;
      end
    end else begin
      next_s.pre = s.pre + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cv.adc_tick = s.tick;

endmodule : scs_adc_clk_div

/* File: scs_conv_timer.sv */
`timescale 1ns/100ps
module scs_conv_timer (
  // Clock and reset
  input logic mclk,
  input logic reset_n,
  // Conversion link
  scs_conv_if.tmr cv
);
  import scs_pkg::*;

  typedef struct packed {
    logic busy;
    logic [CONV_CNT_W-1:0] cnt;
    logic done;
  } scs_tmr_t;

  scs_tmr_t s;
  scs_tmr_t next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (cv.start) begin
      next_s.busy = 1'b1;
      next_s.cnt = '0;
    end else if (s.busy && cv.adc_tick) begin
      if (s.cnt == CONV_CLOCKS[cv.res_sel] - 12'h001) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cv.done = s.done;

endmodule : scs_conv_timer

/* File: scs_sequencer.sv */
// How it works
// - Channel-one start converts with channel-one setups
// - Channel-two start converts with channel-two setups
// - Temperature start with selector zero converts sensor with temperature setups
// - Core stalled while a conversion runs
// - Start bits self-clear when conversion completes
// - Channel-one start wins over all others
// - Channel-two start wins over temperature
// - Nonzero selector converts single-ended signal per channel
// - Selector bits 11-8 pick ground-referenced source
// - Codes 2,3 amplifier; 6,7 buffered converter
// - Codes 4-7 force fixed reduced gain
// - Setup A: gain, clock, resolution, bit7 unused
// - Setup A bit3 offset sign, 2-0 magnitude
// - Setup B: bias and reference fields only
// - Setup B resets 0070h, others zero
// - Ten registers at addresses 00h to 09h
// - Indirect access; action bit cleared when done
// - Only low eight address bits decoded
// - Result registers read-only, written by conversions
`timescale 1ns/100ps
module scs_sequencer (
  // Clock and reset
  input logic mclk,
  input logic reset_n,
  // Core indirect module ports
  input logic [15:0] module_data_port,
  input logic [15:0] module_address_port,
  input logic [15:0] module_action_port,
  output logic [15:0] module_read_data,
  output logic module_read_load,
  output logic module_action_clear,
  output logic core_stall,
  // Analog front end
  input logic [15:0] fe_result,
  output logic fe_converting,
  output scs_pkg::scs_src_t fe_source,
  output logic [3:0] fe_source_selector,
  output logic [4:0] fe_gain,
  output logic fe_gain_fixed,
  output logic fe_amp_large,
  output logic fe_unity_buffer,
  output logic [2:0] fe_conv_clock,
  output logic [2:0] fe_resolution,
  output logic fe_offset_sign,
  output logic [2:0] fe_offset_magnitude,
  output logic [2:0] fe_bias,
  output logic [1:0] fe_reference,
  output logic fe_adc_tick
);
  import scs_pkg::*;

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    scs_state_t st;
    logic [15:0] control;
    logic [NUM_SRC-1:0][15:0] setup_a;
    logic [NUM_SRC-1:0][15:0] setup_b;
    logic [NUM_SRC-1:0][15:0] result;
    logic served;
    logic [15:0] rd_data;
    logic rd_load;
    logic act_clear;
    logic stall;
    logic conv_start;
    logic busy;
    scs_src_t src;
    logic [3:0] sel;
    logic [4:0] gain;
    logic gain_fixed;
    logic amp_large;
    logic unity_buf;
    logic [2:0] clk;
    logic [2:0] res;
    logic off_sign;
    logic [2:0] off_mag;
    logic [2:0] bias;
    logic [1:0] ref_sel;
  } scs_seq_t;

  scs_seq_t s;
  scs_seq_t next_s;
  scs_conv_if cv ();

  logic go;
  logic rd;
  logic [ADDR_DECODE_W-1:0] addr;
  logic [3:0] sel_now;
  logic any_start;

  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic scs_seq_t reset_state();
    scs_seq_t r;
    r = '0;
    r.st = ST_IDLE;
    r.control = RST_CONTROL;
    for (int i = 0; i < NUM_SRC; i++) begin
      r.setup_a[i] = RST_SETUP_A;
      r.setup_b[i] = RST_SETUP_B;
      r.result[i] = RST_RESULT;
    end
    r.src = SRC_CH1;
    return r;
  endfunction : reset_state

  // Readback of the addressed register
  function automatic logic [15:0] read_reg(input logic [ADDR_DECODE_W-1:0] a);
    logic [15:0] v;
    v = 16'h0000;
    if (a == ADDR_CONTROL) begin
      v = s.control;
    end
    for (int i = 0; i < NUM_SRC; i++) begin
      if (a == ADDR_RESULT[i]) begin
        v = s.result[i];
      end
      if (a == ADDR_SETUP_A[i]) begin
        v = s.setup_a[i] & MASK_SETUP_A[i];
      end
      if (a == ADDR_SETUP_B[i]) begin
        v = s.setup_b[i] & MASK_SETUP_B[i];
      end
    end
    return v;
  endfunction : read_reg

  // Fixed reduced gain codes
  function automatic logic gain_forced(input logic [3:0] sel);
    return (sel >= SEL_SUPPLY) && (sel <= SEL_BUF_LARGE);
  endfunction : gain_forced

  // Large amplifier on the path
  function automatic logic routes_large_amp(input logic [3:0] sel);
    return (sel == SEL_LARGE_AMP) || (sel == SEL_BUF_LARGE);
  endfunction : routes_large_amp

  // Amplifier as unity buffer for the converter output
  function automatic logic routes_unity_buffer(input logic [3:0] sel);
    return (sel == SEL_BUF_SMALL) || (sel == SEL_BUF_LARGE);
  endfunction : routes_unity_buffer

  // Register slot of a source
  function automatic int src_slot(input scs_src_t src);
    return int'(src);
  endfunction : src_slot

  // ********************************************************
  // Port decode
  // ********************************************************
  always_comb begin
    go = module_action_port[ACTION_GO_BIT];
    rd = module_action_port[ACTION_READ_BIT];
    addr = module_address_port[ADDR_DECODE_W-1:0];
    sel_now = s.control[SEL_LSB +: 4];
    any_start = |(s.control & START_BITS_MASK);
  end

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    int idx;
    logic launch;
    idx = 0;
    launch = 1'b0;
    next_s = s;
    next_s.rd_load = 1'b0;
    next_s.act_clear = 1'b0;
    next_s.conv_start = 1'b0;
    if (!go) begin
      next_s.served = 1'b0;
    end
    unique case (s.st)
      ST_IDLE: begin
        if (any_start) begin
          if (s.control[START_CH1_BIT]) begin
            next_s.src = SRC_CH1;
            launch = 1'b1;
          end else if (s.control[START_CH2_BIT]) begin
            next_s.src = SRC_CH2;
            launch = 1'b1;
          end else if (sel_now != SEL_NONE) begin
            // Undefined request: drop it, no conversion
            next_s.control[START_TEMP_BIT] = 1'b0;
            next_s.stall = 1'b0;
          end else begin
            next_s.src = SRC_TEMP;
            launch = 1'b1;
          end
        end else if (go && !s.served) begin
          next_s.served = 1'b1;
          next_s.act_clear = 1'b1;
          if (rd) begin
            next_s.rd_data = read_reg(addr);
            next_s.rd_load = 1'b1;
          end else begin
            if (addr == ADDR_CONTROL) begin
              next_s.control = module_data_port & MASK_CONTROL;
              next_s.stall = |(module_data_port & START_BITS_MASK);
            end
            for (int i = 0; i < NUM_SRC; i++) begin
              if (addr == ADDR_SETUP_A[i]) begin
                next_s.setup_a[i] = module_data_port & MASK_SETUP_A[i];
              end
              if (addr == ADDR_SETUP_B[i]) begin
                next_s.setup_b[i] = module_data_port & MASK_SETUP_B[i];
              end
            end
            // Result addresses take no write
          end
        end
        if (launch) begin
          idx = src_slot(next_s.src);
          next_s.st = ST_CONVERT;
          next_s.busy = 1'b1;
          next_s.stall = 1'b1;
          next_s.conv_start = 1'b1;
          next_s.sel = sel_now;
          next_s.gain = s.setup_a[idx][GAIN_LSB +: 5];
          next_s.clk = s.setup_a[idx][CLK_LSB +: 3];
          next_s.res = s.setup_a[idx][RES_LSB +: 3];
          next_s.off_sign = s.setup_a[idx][OFFSET_SIGN_BIT];
          next_s.off_mag = s.setup_a[idx][OFFSET_MAG_LSB +: 3];
          next_s.bias = s.setup_b[idx][BIAS_LSB +: 3];
          next_s.ref_sel = s.setup_b[idx][REF_LSB +: 2];
          next_s.gain_fixed = gain_forced(sel_now);
          next_s.amp_large = routes_large_amp(sel_now);
          next_s.unity_buf = routes_unity_buffer(sel_now);
        end
      end
      ST_CONVERT: begin
        if (cv.done) begin
          idx = src_slot(s.src);
          next_s.result[idx] = fe_result;
          next_s.control = s.control & ~START_BITS_MASK;
          next_s.stall = 1'b0;
          next_s.st = ST_IDLE;
          next_s.busy = 1'b0;
        end
      end
      default: begin
        next_s = reset_state();
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s <= reset_state();
    end else begin
      s <= next_s;
    end
  end

  // ********************************************************
  // Converter timing
  // ********************************************************
  assign cv.start = s.conv_start;
  assign cv.clk_sel = s.clk;
  assign cv.res_sel = s.res;

  scs_adc_clk_div u_clk_div (
    .mclk(mclk),
    .reset_n(reset_n),
    .cv(cv.div)
  );

  scs_conv_timer u_timer (
    .mclk(mclk),
    .reset_n(reset_n),
    .cv(cv.tmr)
  );

  // ********************************************************
  // Outputs
  // ********************************************************
  assign module_read_data = s.rd_data;
  assign module_read_load = s.rd_load;
  assign module_action_clear = s.act_clear;
  assign core_stall = s.stall;
  assign fe_converting = s.busy;
  assign fe_source = s.src;
  assign fe_source_selector = s.sel;
  assign fe_gain = s.gain;
  assign fe_gain_fixed = s.gain_fixed;
  assign fe_amp_large = s.amp_large;
  assign fe_unity_buffer = s.unity_buf;
  assign fe_conv_clock = s.clk;
  assign fe_resolution = s.res;
  assign fe_offset_sign = s.off_sign;
  assign fe_offset_magnitude = s.off_mag;
  assign fe_bias = s.bias;
  assign fe_reference = s.ref_sel;
  assign fe_adc_tick = cv.adc_tick;

endmodule : scs_sequencer

/* File: scs_sequencer_props.sv */
`timescale 1ns/100ps
module scs_sequencer_props (
  // Clock and reset
  input logic mclk,
  input logic reset_n,
  // Core side
  input logic [15:0] module_action_port,
  input logic module_read_load,
  input logic module_action_clear,
  input logic core_stall,
  // Front end
  input logic fe_converting,
  input scs_pkg::scs_src_t fe_source,
  input logic [3:0] fe_source_selector,
  input logic [4:0] fe_gain,
  input logic fe_gain_fixed,
  input logic fe_amp_large,
  input logic fe_unity_buffer
);
  import scs_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence conv_hold;
    fe_converting ##1 fe_converting;
  endsequence
  sequence conv_end;
    fe_converting ##1 !fe_converting;
  endsequence
  stall_holds_a: assert property (fe_converting |-> core_stall)
    else $error("stall low during conversion");
  stall_release_a: assert property (conv_end |-> !core_stall)
    else $error("stall kept after conversion end");
  clear_pulse_a: assert property (module_action_clear |=> !module_action_clear)
    else $error("action clear longer than one cycle");
  load_with_clear_a: assert property (module_read_load |-> module_action_clear)
    else $error("read load without action clear");
  clear_cause_a: assert property (module_action_clear |-> $past(module_action_port[15]))
    else $error("action clear without go bit");
  no_access_busy_a: assert property (fe_converting |-> !module_action_clear)
    else $error("access served during conversion");
  fixed_gain_a: assert property (fe_converting |-> fe_gain_fixed == (fe_source_selector inside {[4'h4:4'h7]}))
    else $error("fixed gain flag wrong");
  buffer_route_a: assert property (fe_converting |->
    fe_unity_buffer == (fe_source_selector inside {4'h6, 4'h7})
    && fe_amp_large == (fe_source_selector inside {4'h3, 4'h7}))
    else $error("amplifier routing wrong");
  settings_hold_a: assert property (conv_hold |-> $stable(fe_source) && $stable(fe_gain)
    && $stable(fe_source_selector))
    else $error("settings moved during conversion");
  temp_plain_a: assert property (fe_converting && fe_source == SRC_TEMP |-> fe_source_selector == SEL_NONE)
    else $error("temperature converted with selector");
endmodule : scs_sequencer_props
bind scs_sequencer scs_sequencer_props u_props (.mclk(mclk), .reset_n(reset_n),
  .module_action_port(module_action_port), .module_read_load(module_read_load),
  .module_action_clear(module_action_clear), .core_stall(core_stall), .fe_converting(fe_converting),
  .fe_source(fe_source), .fe_source_selector(fe_source_selector), .fe_gain(fe_gain),
  .fe_gain_fixed(fe_gain_fixed), .fe_amp_large(fe_amp_large), .fe_unity_buffer(fe_unity_buffer));

/* File: scs_core_model.sv */
`timescale 1ns/100ps
module scs_core_model (
  // Clock
  input logic mclk,
  // Module ports
  output logic [15:0] module_data_port,
  output logic [15:0] module_address_port,
  output logic [15:0] module_action_port,
  input logic [15:0] module_read_data,
  input logic module_action_clear
);
  initial begin
    module_data_port = 16'h0000;
    module_address_port = 16'h0000;
    module_action_port = 16'h0000;
  end
  // One transfer, go held until the clear pulse has been sampled
  task automatic access(input logic rd, input logic [15:0] addr, input logic [15:0] data,
                        output logic [15:0] rdata, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(negedge mclk);
    module_address_port = addr;
    module_data_port = data;
    module_action_port = {1'b1, rd, 14'h0000};
    while (n < 64 && !ok) begin
      @(negedge mclk);
      n++;
      ok = (module_action_clear === 1'b1);
    end
    rdata = module_read_data;
    @(negedge mclk);
    module_action_port = 16'h0000;
    module_data_port = ~data;
  endtask : access
endmodule : scs_core_model

/* File: sensor_conversion_sequencer_tb_top.sv */
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin error_cnt++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module sensor_conversion_sequencer_tb_top;
  import scs_pkg::*;
  typedef struct {string nm; logic [15:0] ex;} scs_note_t;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] fe_result = 16'h0000;
  logic [15:0] md, ma, mact, mrd, last_res;
  logic mload, mclr, stall, conv_on, gfix, alarge, ubuf, tick, osign;
  scs_src_t src;
  logic [3:0] sel;
  logic [4:0] gain;
  logic [2:0] cclk, res_sel, omag, bias;
  logic [1:0] refs;
  logic [15:0] sa [0:2];
  logic [15:0] sb [0:2];
  int error_cnt = 0, samples_checked = 0, cyc = 0, seed = 5;
  scs_note_t notes[$];
  scs_note_t cur;
  always #5 mclk = ~mclk;
  scs_sequencer dut (.mclk(mclk), .reset_n(reset_n), .module_data_port(md), .module_address_port(ma),
    .module_action_port(mact), .module_read_data(mrd), .module_read_load(mload),
    .module_action_clear(mclr), .core_stall(stall), .fe_result(fe_result), .fe_converting(conv_on),
    .fe_source(src), .fe_source_selector(sel), .fe_gain(gain), .fe_gain_fixed(gfix),
    .fe_amp_large(alarge), .fe_unity_buffer(ubuf), .fe_conv_clock(cclk), .fe_resolution(res_sel),
    .fe_offset_sign(osign), .fe_offset_magnitude(omag), .fe_bias(bias), .fe_reference(refs),
    .fe_adc_tick(tick));
  scs_core_model core (.mclk(mclk), .module_data_port(md), .module_address_port(ma),
    .module_action_port(mact), .module_read_data(mrd), .module_action_clear(mclr));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  // ********************************************************
  // Read result checker and watchdog
  // ********************************************************
  always @(negedge mclk) begin
    if (mload === 1'b1) begin
      if (notes.size() == 0) begin
        error_cnt++;
        $display("ERROR read_data expected nothing seen %h", mrd);
      end else begin
        cur = notes.pop_front();
        `CHK(cur.nm, cur.ex, mrd)
      end
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 95000) begin
      error_cnt++;
      $display("ERROR run_length expected finish seen hang");
      end_sim();
    end
  end
  // ********************************************************
  // Transfer helpers
  // ********************************************************
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] r;
    logic ok;
    core.access(1'b0, a, d, r, ok);
    `CHK("write_ack", 1'b1, ok)
  endtask : wr
  task automatic rd(input string nm, input logic [15:0] a, input logic [15:0] ex);
    logic [15:0] r;
    logic ok;
    notes.push_back('{nm, ex});
    core.access(1'b1, a, 16'h0000, r, ok);
    `CHK("read_ack", 1'b1, ok)
  endtask : rd
  task automatic wait_idle(output int t);
    int n;
    n = 0;
    t = 0;
    while (stall !== 1'b0 && n < 30000) begin
      @(negedge mclk);
      n++;
      if (tick === 1'b1) t++;
    end
    `CHK("stall_release", 1'b0, stall)
  endtask : wait_idle
  task automatic conv(input logic [15:0] ctl, input int i);
    logic [3:0] s;
    logic [2:0] rt;
    int t;
    s = ctl[11:8];
    rt = {s inside {[4'h4:4'h7]}, s inside {4'h6, 4'h7}, s inside {4'h3, 4'h7}};
    last_res = 16'($random(seed));
    fe_result = last_res;
    wr(16'(ADDR_CONTROL), ctl);
    `CHK("stall", 1'b1, stall)
    @(negedge mclk);
    `CHK("converting", 1'b1, conv_on)
    `CHK("source", scs_src_t'(i), src)
    `CHK("selector", s, sel)
    `CHK("gain", sa[i][15:11], gain)
    `CHK("clk_res", 6'h00, {cclk, res_sel})
    `CHK("offset", sa[i][3:0], {osign, omag})
    `CHK("bias_ref", {sb[i][6:4], sb[i][1:0]}, {bias, refs})
    `CHK("route", rt, {gfix, ubuf, alarge})
    wait_idle(t);
    `CHK("tick_count", int'(CONV_CLOCKS[0]), t)
    `CHK("converting_end", 1'b0, conv_on)
    rd("control_after", 16'(ADDR_CONTROL), ctl & 16'h0f00);
    rd("result", 16'(ADDR_RESULT[i]), last_res);
    $display("test conversion %0d done", i);
  endtask : conv
  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    logic [15:0] w;
    int t;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    for (int a = 0; a < 10; a++) begin
      rd("reset_value", 16'(a), (a % 3 == 0 && a > 0) ? RST_SETUP_B : 16'h0000);
    end
    rd("unmapped", 16'h000a, 16'h0000);
    wr(16'(ADDR_RESULT[0]), 16'hffff);
    rd("result_ro", 16'(ADDR_RESULT[0]), RST_RESULT);
    wr(16'h3300, 16'hfaf8);
    rd("control_mask", 16'h5500, 16'h0a00);
    for (int i = 0; i < 3; i++) begin
      w = 16'($random(seed)) & 16'hf88f;
      wr(16'(ADDR_SETUP_A[i]), w);
      sa[i] = w & MASK_SETUP_A[i];
      w = 16'($random(seed));
      wr(16'(ADDR_SETUP_B[i]), w);
      sb[i] = w & MASK_SETUP_B[i];
      rd("setup_a", {8'h5a, ADDR_SETUP_A[i]}, sa[i]);
      rd("setup_b", 16'(ADDR_SETUP_B[i]), sb[i]);
    end
    $display("test registers done");
    conv(16'h0007, 0);
    conv(16'h0703, 1);
    conv(16'h0001, 2);
    wr(16'(ADDR_CONTROL), 16'h0301);
    wait_idle(t);
    `CHK("refused_ticks", 0, t)
    rd("temp_refused", 16'(ADDR_CONTROL), 16'h0300);
    rd("temp_kept", 16'(ADDR_RESULT[2]), last_res);
    $display("test refused temperature done");
    end_sim();
  end
endmodule : sensor_conversion_sequencer_tb_top
